// File: verilog/aam_map.svh
// register map, field positions, reset values and codes for the alarm monitor
`ifndef AAM_MAP_SVH
`define AAM_MAP_SVH

// register byte-free offsets (index on the plain port)
`define AAM_ADDR_BYPASS 8'h2e
`define AAM_ADDR_BYPCFG 8'h2f
`define AAM_ADDR_ADCCFG 8'h30
`define AAM_ADDR_POLCFG 8'h31
`define AAM_ADDR_MASK 8'h32
`define AAM_ADDR_ACT 8'h33
`define AAM_ADDR_STATUS 8'h34
`define AAM_ADDR_THR0 8'h35
`define AAM_ADDR_THR1 8'h36
`define AAM_ADDR_THR2 8'h37
`define AAM_ADDR_RES0 8'h38
`define AAM_ADDR_RES1 8'h39
`define AAM_ADDR_RES2 8'h3a
`define AAM_ADDR_ACTIVE 8'h3b

// reset values
`define AAM_RST_MASK 16'hffff
`define AAM_RST_THR 16'hff00
`define AAM_RST_ADCCFG 16'h0000

// alarm flag positions
`define AAM_BIT_IN0 0
`define AAM_BIT_IN1 1
`define AAM_BIT_TMP 2
`define AAM_BIT_CRC 3
`define AAM_BIT_WDT 4
`define AAM_BIT_REF 5
`define AAM_BIT_TWARN 6
`define AAM_BIT_TERR 7
`define AAM_BIT_OMON 8
`define AAM_NUM_FLAGS 9
`define AAM_NUM_ACT 8

// threshold fill nibbles and disable limits
`define AAM_HI_FILL 4'hf
`define AAM_LO_FILL 4'h0
`define AAM_LIM_OFF_HI 12'hfff
`define AAM_LIM_OFF_LO 12'h000

// response codes
`define AAM_ACT_NONE 2'h0
`define AAM_ACT_CLEAR 2'h1
`define AAM_ACT_ALMV 2'h2
`define AAM_ACT_HIZ 2'h3

// field positions in the config registers
`define AAM_CFG_FLT_LSB 7
`define AAM_CFG_FLT_W 3
`define AAM_CFG_HYST_W 7
`define AAM_BYP_OFST 0
`define AAM_BYP_DATA 1
`define AAM_POL_LVL 0
`define AAM_POL_GATE_N 1

`endif

// File: verilog/aam_pkg.sv
// types shared by the alarm monitor files
package aam_pkg;
  typedef enum logic [3:0] {
    AAM_OUT_NORMAL = 4'h1,
    AAM_OUT_CLEAR = 4'h2,
    AAM_OUT_ALMV = 4'h4,
    AAM_OUT_HIZ = 4'h8
  } aam_out_e;
endpackage

// File: verilog/aam_chan_det.sv
// per-channel out-of-range detector with fault count and hysteresis
`timescale 1ns/10ps
`include "aam_map.svh"

module aam_chan_det #(
  parameter int CNT_W = 3
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // conversion result
  input wire logic result_valid_i,
  input wire logic [11:0] result_i,
  // limits and settings
  input wire logic [7:0] thr_hi_i,
  input wire logic [7:0] thr_lo_i,
  input wire logic [CNT_W-1:0] fault_limit_i,
  input wire logic [6:0] hyst_i,
  // detector state
  output logic alarm_o
);

  logic [11:0] hi_full;
  logic [11:0] lo_full;
  logic [12:0] hi_rel;
  logic [12:0] lo_rel;
  logic disabled;
  logic outside;
  logic inside_hyst;
  logic [CNT_W-1:0] cnt_reg;
  logic alarm_reg;

  // fixed low nibbles widen the 8-bit limits
  assign hi_full = {thr_hi_i, `AAM_HI_FILL};
  assign lo_full = {thr_lo_i, `AAM_LO_FILL};
  assign disabled = (hi_full == `AAM_LIM_OFF_HI) &&
                    (lo_full == `AAM_LIM_OFF_LO);
  assign outside = !disabled &&
                   ((result_i > hi_full) || (result_i < lo_full));
  // release band is narrowed on both sides
  assign hi_rel = {1'b0, hi_full} - {6'h00, hyst_i};
  assign lo_rel = {1'b0, lo_full} + {6'h00, hyst_i};
  assign inside_hyst = ({1'b0, result_i} < hi_rel) &&
                       ({1'b0, result_i} > lo_rel) &&
                       !hi_rel[12];

  // consecutive failures of either limit share one counter
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
    end else if (result_valid_i) begin
      if (!outside) begin
        cnt_reg <= '0;
      end else if (cnt_reg != fault_limit_i) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // alarm sets on the k+1th failure, releases inside hysteresis or when the limits are disabled
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_reg <= 1'b0;
    end else if (result_valid_i) begin
      if (outside && cnt_reg == fault_limit_i) begin
        alarm_reg <= 1'b1;
      end else if (disabled || inside_hyst) begin
        alarm_reg <= 1'b0;
      end
    end
  end

  assign alarm_o = alarm_reg;
endmodule

// File: verilog/aam_top.sv
// alarm monitor and response logic with its register file
`timescale 1ns/10ps
`include "aam_map.svh"

module aam_top #(
  parameter int CNT_W = `AAM_CFG_FLT_W,
  parameter int DAC_W = 16
) (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic por_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // converter side
  input wire logic conv_done_i,
  input wire logic [1:0] conv_chan_i,
  input wire logic [11:0] conv_raw_i,
  input wire logic [11:0] stored_offset_i,
  input wire logic omon_meas_i,
  input wire logic omon_ok_i,
  // fault sources
  input wire logic crc_fault_i,
  input wire logic watchdog_fault_i,
  input wire logic reference_fault_flag_i,
  input wire logic thermal_warning_flag_i,
  input wire logic thermal_error_flag_i,
  input wire logic ext_input_1_i,
  // dac side
  input wire logic [DAC_W-1:0] dac_active_code_i,
  input wire logic [DAC_W-1:0] dac_clear_code_i,
  output logic [DAC_W-1:0] dac_code_o,
  output logic dac_reload_o,
  output logic analog_output_almv_sel_o,
  output logic analog_output_almv_high_o,
  output logic analog_output_hiz_o,
  // host fault pin
  output logic fault_pin_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] bypass_value_reg;
  logic offset_substitute_enable_reg;
  logic conversion_substitute_enable_reg;
  logic [15:0] adc_cfg_reg;
  logic fault_level_polarity_reg;
  logic pin_polarity_gate_n_reg;
  logic [15:0] mask_reg;
  logic [15:0] fault_response_select_reg;
  logic [15:0] thr_reg [0:2];
  logic [11:0] res_reg [0:2];
  logic [`AAM_NUM_FLAGS-1:0] flag_reg;
  logic [`AAM_NUM_FLAGS-1:0] flag_next;
  logic [`AAM_NUM_FLAGS-1:0] cond;
  logic [15:0] rdata_reg;
  logic status_rd;
  logic omon_alarm_reg;
  logic [2:0] det_alarm;
  logic [11:0] corr_result;
  logic [11:0] chan_result;
  logic [2:0] chan_valid;
  logic [1:0] act_level;
  logic [1:0] act_level_reg;
  logic [DAC_W-1:0] dac_code_reg;
  logic reload_reg;
  aam_pkg::aam_out_e out_state_reg;
  aam_pkg::aam_out_e out_state_next;

  // highest response among active flags with a nonzero select
  function automatic logic [1:0] max_resp(
    input logic [`AAM_NUM_ACT-1:0] flags,
    input logic [15:0] sel
  );
    logic [1:0] best;
    best = `AAM_ACT_NONE;
    for (int i = 0; i < `AAM_NUM_ACT; i++) begin
      if (flags[i] && sel[2*i +: 2] > best) begin
        best = sel[2*i +: 2];
      end
    end
    return best;
  endfunction

  // ----------------------------------------------------------------
  // conversion data path
  // ----------------------------------------------------------------
  // bypass value may replace the stored offset correction
  assign corr_result = offset_substitute_enable_reg ?
    conv_raw_i + bypass_value_reg[11:0] :
    conv_raw_i + stored_offset_i;
  // bypass may replace the conversion itself for alarm testing
  assign chan_result = conversion_substitute_enable_reg ?
    bypass_value_reg[11:0] : corr_result;

  // readback registers for the three monitored channels
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 3; i++) begin
        res_reg[i] <= 12'h000;
      end
    end else if (conv_done_i && conv_chan_i < 2'd3) begin
      res_reg[conv_chan_i] <= chan_result;
    end
  end

  // one independent detector per channel
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_det
      assign chan_valid[g] = conv_done_i && (conv_chan_i == 2'(g));
      aam_chan_det #(
        .CNT_W(CNT_W)
      ) u_det (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .result_valid_i(chan_valid[g]),
        .result_i(chan_result),
        .thr_hi_i(thr_reg[g][15:8]),
        .thr_lo_i(thr_reg[g][7:0]),
        .fault_limit_i(adc_cfg_reg[`AAM_CFG_FLT_LSB +: CNT_W]),
        .hyst_i(adc_cfg_reg[`AAM_CFG_HYST_W-1:0]),
        .alarm_o(det_alarm[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // output-monitor alarm
  // ----------------------------------------------------------------
  // diverted output cannot match the code, so the monitor complains;
  // it settles only at the next measurement once the output is back
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      omon_alarm_reg <= 1'b0;
    end else if (act_level_reg == `AAM_ACT_ALMV ||
                 act_level_reg == `AAM_ACT_HIZ) begin
      omon_alarm_reg <= 1'b1;
    end else if (omon_meas_i) begin
      omon_alarm_reg <= !omon_ok_i;
    end
  end

  // ----------------------------------------------------------------
  // alarm flags
  // ----------------------------------------------------------------
  // thermal and reference comparators arrive as levels
  always_comb begin
    cond = '0;
    cond[`AAM_BIT_IN0] = det_alarm[0];
    cond[`AAM_BIT_IN1] = det_alarm[1];
    cond[`AAM_BIT_TMP] = det_alarm[2];
    cond[`AAM_BIT_CRC] = crc_fault_i;
    cond[`AAM_BIT_WDT] = watchdog_fault_i;
    cond[`AAM_BIT_REF] = reference_fault_flag_i;
    cond[`AAM_BIT_TWARN] = thermal_warning_flag_i;
    cond[`AAM_BIT_TERR] = thermal_error_flag_i;
    cond[`AAM_BIT_OMON] = omon_alarm_reg;
  end

  assign status_rd = reg_rd_i && (reg_addr_i == `AAM_ADDR_STATUS);

  // a live condition wins over the read clear, so nothing is lost
  always_comb begin
    flag_next = status_rd ? '0 : flag_reg;
    flag_next = flag_next | cond;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // pin sees flags and mask only
  assign fault_pin_o = |(flag_reg & ~mask_reg[`AAM_NUM_FLAGS-1:0]);

  // ----------------------------------------------------------------
  // alarm response
  // ----------------------------------------------------------------
  // mask is not consulted; only the first eight flags can act
  assign act_level = max_resp(flag_reg[`AAM_NUM_ACT-1:0],
                              fault_response_select_reg);

  always_comb begin
    case (act_level)
      `AAM_ACT_CLEAR: out_state_next = aam_pkg::AAM_OUT_CLEAR;
      `AAM_ACT_ALMV: out_state_next = aam_pkg::AAM_OUT_ALMV;
      `AAM_ACT_HIZ: out_state_next = aam_pkg::AAM_OUT_HIZ;
      default: out_state_next = aam_pkg::AAM_OUT_NORMAL;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_state_reg <= aam_pkg::AAM_OUT_NORMAL;
      act_level_reg <= `AAM_ACT_NONE;
    end else begin
      out_state_reg <= out_state_next;
      act_level_reg <= act_level;
    end
  end

  // code fed to the dac is overridden while the clear response holds
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dac_code_reg <= '0;
      reload_reg <= 1'b0;
    end else begin
      case (out_state_next)
        aam_pkg::AAM_OUT_CLEAR: dac_code_reg <= dac_clear_code_i;
        default: dac_code_reg <= dac_active_code_i;
      endcase
      reload_reg <= (out_state_reg != aam_pkg::AAM_OUT_NORMAL) &&
                    (out_state_next == aam_pkg::AAM_OUT_NORMAL);
    end
  end

  assign dac_code_o = dac_code_reg;
  assign dac_reload_o = reload_reg;
  assign analog_output_almv_sel_o = out_state_reg == aam_pkg::AAM_OUT_ALMV;
  assign analog_output_hiz_o = out_state_reg == aam_pkg::AAM_OUT_HIZ;
  // pin path only counts when the gate is open (low)
  assign analog_output_almv_high_o = fault_level_polarity_reg ||
    (!pin_polarity_gate_n_reg && ext_input_1_i);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // polarity controls survive system reset, only power-on resets them
  always_ff @(posedge clk_sys_i or posedge por_rst_i) begin
    if (por_rst_i) begin
      fault_level_polarity_reg <= 1'b0;
      pin_polarity_gate_n_reg <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `AAM_ADDR_POLCFG) begin
      fault_level_polarity_reg <= reg_wdata_i[`AAM_POL_LVL];
      pin_polarity_gate_n_reg <= reg_wdata_i[`AAM_POL_GATE_N];
    end
  end

  // remaining control registers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bypass_value_reg <= 16'h0000;
      offset_substitute_enable_reg <= 1'b0;
      conversion_substitute_enable_reg <= 1'b0;
      adc_cfg_reg <= `AAM_RST_ADCCFG;
      mask_reg <= `AAM_RST_MASK;
      fault_response_select_reg <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        thr_reg[i] <= `AAM_RST_THR;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `AAM_ADDR_BYPASS) begin
        bypass_value_reg <= reg_wdata_i;
      end else if (reg_addr_i == `AAM_ADDR_BYPCFG) begin
        offset_substitute_enable_reg <= reg_wdata_i[`AAM_BYP_OFST];
        conversion_substitute_enable_reg <= reg_wdata_i[`AAM_BYP_DATA];
      end else if (reg_addr_i == `AAM_ADDR_ADCCFG) begin
        adc_cfg_reg <= reg_wdata_i;
      end else if (reg_addr_i == `AAM_ADDR_MASK) begin
        mask_reg <= reg_wdata_i;
      end else if (reg_addr_i == `AAM_ADDR_ACT) begin
        fault_response_select_reg <= reg_wdata_i;
      end else if (reg_addr_i == `AAM_ADDR_THR0) begin
        thr_reg[0] <= reg_wdata_i;
      end else if (reg_addr_i == `AAM_ADDR_THR1) begin
        thr_reg[1] <= reg_wdata_i;
      end else if (reg_addr_i == `AAM_ADDR_THR2) begin
        thr_reg[2] <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `AAM_ADDR_BYPASS) begin
        rdata_reg <= bypass_value_reg;
      end else if (reg_addr_i == `AAM_ADDR_BYPCFG) begin
        rdata_reg <= {14'h0000, conversion_substitute_enable_reg,
                      offset_substitute_enable_reg};
      end else if (reg_addr_i == `AAM_ADDR_ADCCFG) begin
        rdata_reg <= adc_cfg_reg;
      end else if (reg_addr_i == `AAM_ADDR_POLCFG) begin
        rdata_reg <= {14'h0000, pin_polarity_gate_n_reg,
                      fault_level_polarity_reg};
      end else if (reg_addr_i == `AAM_ADDR_MASK) begin
        rdata_reg <= mask_reg;
      end else if (reg_addr_i == `AAM_ADDR_ACT) begin
        rdata_reg <= fault_response_select_reg;
      end else if (reg_addr_i == `AAM_ADDR_STATUS) begin
        rdata_reg <= {7'h00, flag_reg};
      end else if (reg_addr_i == `AAM_ADDR_THR0) begin
        rdata_reg <= thr_reg[0];
      end else if (reg_addr_i == `AAM_ADDR_THR1) begin
        rdata_reg <= thr_reg[1];
      end else if (reg_addr_i == `AAM_ADDR_THR2) begin
        rdata_reg <= thr_reg[2];
      end else if (reg_addr_i == `AAM_ADDR_RES0) begin
        rdata_reg <= {4'h0, res_reg[0]};
      end else if (reg_addr_i == `AAM_ADDR_RES1) begin
        rdata_reg <= {4'h0, res_reg[1]};
      end else if (reg_addr_i == `AAM_ADDR_RES2) begin
        rdata_reg <= {4'h0, res_reg[2]};
      end else if (reg_addr_i == `AAM_ADDR_ACTIVE) begin
        rdata_reg <= {12'h000, out_state_reg};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
endmodule

// File: sim/aam_host_model.sv
// host-side model that counts alarm interrupts on the fault pin
`timescale 1ns/10ps
module aam_host_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // fault pin from the device
  input wire logic fault_pin_i,
  // interrupts seen so far
  output logic [7:0] fault_events_o
);
  logic pin_d_reg;
  // count rising edges only; a level pin stays high across many polls
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_d_reg <= 1'b0;
      fault_events_o <= 8'h00;
    end else begin
      pin_d_reg <= fault_pin_i;
      if (fault_pin_i && !pin_d_reg) begin
        fault_events_o <= fault_events_o + 8'h01;
      end
    end
  end
endmodule

// File: sim/aam_top_checker.sv
// port-level assertions for the alarm monitor top
`timescale 1ns/10ps
`include "aam_map.svh"
module aam_top_checker #(
  parameter int DAC_W = 16
) (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic por_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // fault causes
  input wire logic conv_done_i,
  input wire logic omon_meas_i,
  input wire logic crc_fault_i,
  input wire logic watchdog_fault_i,
  input wire logic reference_fault_flag_i,
  input wire logic thermal_warning_flag_i,
  input wire logic thermal_error_flag_i,
  input wire logic ext_input_1_i,
  // dac and pin side
  input wire logic [DAC_W-1:0] dac_active_code_i,
  input wire logic [DAC_W-1:0] dac_code_o,
  input wire logic dac_reload_o,
  input wire logic analog_output_almv_sel_o,
  input wire logic analog_output_almv_high_o,
  input wire logic analog_output_hiz_o,
  input wire logic fault_pin_o
);
  // ----
  // helper logic
  // ----
  logic cause_w;
  logic busy_w;
  logic [3:0] cause_hist_reg;
  // any event that may legally raise a flag or change the pin
  assign cause_w = crc_fault_i | watchdog_fault_i | reference_fault_flag_i |
    thermal_warning_flag_i | thermal_error_flag_i | conv_done_i |
    omon_meas_i | reg_wr_i | reg_rd_i;
  assign busy_w = analog_output_hiz_o | analog_output_almv_sel_o |
    (dac_code_o != dac_active_code_i);
  // four edges cover the conversion to pin pipeline
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cause_hist_reg <= 4'h0;
    end else begin
      cause_hist_reg <= {cause_hist_reg[2:0], cause_w};
    end
  end
  // ----
  // assertions
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i || por_rst_i);
  rdata_hold_a: assert property (
    !$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  reload_pulse_a: assert property (dac_reload_o |=> !dac_reload_o)
    else $error("reload longer than one cycle");
  reload_code_a: assert property (dac_reload_o |-> ##[0:1]
    (dac_code_o == dac_active_code_i))
    else $error("reload without active code");
  reload_cause_a: assert property (dac_reload_o |->
    ($past(busy_w) || $past(busy_w, 2)))
    else $error("reload with no response");
  hiz_over_a: assert property (analog_output_hiz_o |->
    !analog_output_almv_sel_o) else $error("hi-z and alarm voltage together");
  almv_level_a: assert property (
    $changed(analog_output_almv_high_o) |->
    $changed(ext_input_1_i) || $past(reg_wr_i &&
    reg_addr_i == `AAM_ADDR_POLCFG)) else $error("alarm level moved alone");
  pin_rise_a: assert property ($rose(fault_pin_o) |->
    cause_hist_reg != 4'h0) else $error("fault pin rose with no cause");
  pin_fall_a: assert property ($fell(fault_pin_o) |->
    $past(reg_rd_i || reg_wr_i || omon_meas_i)) else $error("pin fell alone");
  cover property ($rose(analog_output_hiz_o));
  cover property (dac_reload_o);
  cover property ($rose(fault_pin_o));
endmodule
bind aam_top aam_top_checker #(.DAC_W(DAC_W)) aam_top_checker_inst (
  .clk_sys_i, .sys_rst_i, .por_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .conv_done_i, .omon_meas_i, .crc_fault_i, .watchdog_fault_i,
  .reference_fault_flag_i, .thermal_warning_flag_i, .thermal_error_flag_i,
  .ext_input_1_i, .dac_active_code_i, .dac_code_o, .dac_reload_o,
  .analog_output_almv_sel_o, .analog_output_almv_high_o,
  .analog_output_hiz_o, .fault_pin_o
);

// File: sim/tb.sv
// self-checking testbench for the alarm monitor
`timescale 1ns/10ps
`include "aam_map.svh"
module tb;
  // ----
  // signals
  // ----
  logic clk = 1'b0, rst = 1'b1, por = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, cdone = 1'b0, omeas = 1'b0, ook = 1'b1;
  logic [1:0] cch = 2'h0;
  logic [11:0] craw = 12'h000, offs = 12'h003;
  logic [4:0] flt = 5'h00;
  logic ext_input_1 = 1'b0;
  logic [15:0] act_code = 16'h1234, clr_code = 16'h8000, rdata, dcode;
  logic rel, asel, ahigh, hiz, pin;
  logic [7:0] nev;
  int err_count = 0, cmp_count = 0, nrel = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  aam_top aam_top_inst (
    .clk_sys_i(clk), .sys_rst_i(rst), .por_rst_i(por), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .conv_done_i(cdone), .conv_chan_i(cch), .conv_raw_i(craw),
    .stored_offset_i(offs), .omon_meas_i(omeas), .omon_ok_i(ook),
    .crc_fault_i(flt[0]), .watchdog_fault_i(flt[1]),
    .reference_fault_flag_i(flt[2]), .thermal_warning_flag_i(flt[3]),
    .thermal_error_flag_i(flt[4]), .ext_input_1_i(ext_input_1),
    .dac_active_code_i(act_code), .dac_clear_code_i(clr_code),
    .dac_code_o(dcode), .dac_reload_o(rel), .analog_output_almv_sel_o(asel),
    .analog_output_almv_high_o(ahigh), .analog_output_hiz_o(hiz),
    .fault_pin_o(pin)
  );
  aam_host_model aam_host_model_inst (.clk_sys_i(clk), .sys_rst_i(rst),
    .fault_pin_i(pin), .fault_events_o(nev));
  // reload pulses seen at the dac
  always @(posedge clk) begin
    if (rel === 1'b1) begin
      nrel <= nrel + 1;
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, exp);
  endtask
  task automatic conv(input logic [1:0] ch, input logic [11:0] raw);
    @(posedge clk);
    cdone <= 1'b1;
    cch <= ch;
    craw <= raw;
    @(posedge clk);
    cdone <= 1'b0;
    cyc(2);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    cyc(6);
    rst <= 1'b0;
    por <= 1'b0;
    rdc(`AAM_ADDR_MASK, `AAM_RST_MASK);
    rdc(`AAM_ADDR_THR2, `AAM_RST_THR);
    rdc(`AAM_ADDR_ADCCFG, `AAM_RST_ADCCFG);
    rdc(`AAM_ADDR_POLCFG, 16'h0002);
    rdc(`AAM_ADDR_STATUS, 16'h0000);
    rdc(8'h10, 16'h0000);
    done("reset");
    wr16(`AAM_ADDR_POLCFG, 16'h0001);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rdc(`AAM_ADDR_POLCFG, 16'h0001);
    rdc(`AAM_ADDR_MASK, `AAM_RST_MASK);
    conv(2'h0, 12'h100);
    rdc(`AAM_ADDR_RES0, 16'h0103);
    wr16(`AAM_ADDR_BYPASS, 16'h0123);
    wr16(`AAM_ADDR_BYPCFG, 16'h0002);
    conv(2'h2, 12'hfff);
    rdc(`AAM_ADDR_RES2, 16'h0123);
    wr16(`AAM_ADDR_BYPASS, 16'h0005);
    wr16(`AAM_ADDR_BYPCFG, 16'h0001);
    conv(2'h1, 12'h100);
    rdc(`AAM_ADDR_RES1, 16'h0105);
    wr16(`AAM_ADDR_BYPCFG, 16'h0000);
    offs <= 12'h000;
    done("bypass");
    // high 80f, low 400, two faults tolerated, hysteresis 10
    wr16(`AAM_ADDR_THR0, 16'h8040);
    wr16(`AAM_ADDR_ADCCFG, 16'h0110);
    repeat (3) conv(2'h0, 12'h80f);
    rdc(`AAM_ADDR_STATUS, 16'h0000);
    conv(2'h0, 12'h900);
    conv(2'h0, 12'h100);
    rdc(`AAM_ADDR_STATUS, 16'h0000);
    // an in-range result restarts the count
    conv(2'h0, 12'h500);
    conv(2'h0, 12'h810);
    rdc(`AAM_ADDR_STATUS, 16'h0000);
    conv(2'h0, 12'h900);
    conv(2'h0, 12'h810);
    rdc(`AAM_ADDR_STATUS, 16'h0001);
    rdc(`AAM_ADDR_STATUS, 16'h0001);
    conv(2'h0, 12'h7ff);
    rdc(`AAM_ADDR_STATUS, 16'h0001);
    conv(2'h0, 12'h411);
    rdc(`AAM_ADDR_STATUS, 16'h0001);
    rdc(`AAM_ADDR_STATUS, 16'h0000);
    wr16(`AAM_ADDR_THR0, `AAM_RST_THR);
    done("limits");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) flt <= 5'h01 << i;
      cyc(3);
      flt <= 5'h00;
      cyc(2);
      rdc(`AAM_ADDR_STATUS, 16'h0008 << i);
      rdc(`AAM_ADDR_STATUS, 16'h0000);
    end
    done("sources");
    wr16(`AAM_ADDR_ACT, 16'h0040);
    flt <= 5'h01;
    cyc(5);
    #1;
    chk("dac code", dcode, clr_code);
    chk("fault pin", {15'h0, pin}, 16'h0000);
    rdc(`AAM_ADDR_ACTIVE, 16'h0002);
    @(posedge clk) flt <= 5'h00;
    cyc(2);
    rdc(`AAM_ADDR_STATUS, 16'h0008);
    cyc(4);
    #1;
    chk("dac code", dcode, act_code);
    chk("reloads", 16'(nrel), 16'h0001);
    done("clear code");
    wr16(`AAM_ADDR_ACT, 16'h0380);
    flt <= 5'h03;
    cyc(5);
    #1;
    chk("hi-z", {15'h0, hiz}, 16'h0001);
    rdc(`AAM_ADDR_ACTIVE, 16'h0008);
    @(posedge clk) flt <= 5'h01;
    cyc(2);
    rdc(`AAM_ADDR_STATUS, 16'h0118);
    cyc(4);
    rdc(`AAM_ADDR_ACTIVE, 16'h0004);
    chk("alarm sel", {15'h0, asel}, 16'h0001);
    for (int j = 0; j < 8; j++) begin
      wr16(`AAM_ADDR_POLCFG, 16'(j & 3));
      ext_input_1 <= j[2];
      cyc(1);
      #1;
      chk("alarm high", {15'h0, ahigh},
          {15'h0, j[0] | (!j[1] & j[2])});
    end
    wr16(`AAM_ADDR_ACT, 16'h0000);
    cyc(3);
    #1;
    chk("alarm sel", {15'h0, asel}, 16'h0000);
    rdc(`AAM_ADDR_ACTIVE, 16'h0001);
    chk("reloads", 16'(nrel), 16'h0002);
    @(posedge clk) omeas <= 1'b1;
    @(posedge clk) omeas <= 1'b0;
    cyc(2);
    rdc(`AAM_ADDR_STATUS, 16'h0108);
    rdc(`AAM_ADDR_STATUS, 16'h0008);
    done("alarm voltage");
    chk("fault pin", {15'h0, pin}, 16'h0000);
    wr16(`AAM_ADDR_MASK, 16'hfff7);
    cyc(1);
    #1;
    chk("fault pin", {15'h0, pin}, 16'h0001);
    chk("pin events", {8'h0, nev}, 16'h0001);
    @(posedge clk) flt <= 5'h00;
    cyc(2);
    rdc(`AAM_ADDR_STATUS, 16'h0008);
    cyc(1);
    #1;
    chk("fault pin", {15'h0, pin}, 16'h0000);
    done("fault pin");
    end_sim;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim;
  end
endmodule
